// >>> rtl/mce_defs.svh
// Purpose: Offsets, field positions, codes and timing terms of the constant engine
// Assumes: 32-bit APB data, one register per aligned word
// Notes: Definitions only
`ifndef MCE_DEFS_SVH
`define MCE_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MCE_OFF_CTRL 12'h000
`define MCE_OFF_SIZE 12'h004
`define MCE_OFF_STATUS 12'h008
`define MCE_OFF_MEMADDR 12'h00c
`define MCE_OFF_MEMDATA 12'h010
`define MCE_OFF_ESTSEL 12'h014
`define MCE_OFF_ESTIMATE 12'h018
`define MCE_OFF_LASTRUN 12'h01c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MCE_CTRL_BINFIELD 12
`define MCE_CTRL_PROJ 13
`define MCE_CTRL_CRT 14
`define MCE_CTRL_START 31
`define MCE_SIZE_EXPDIG_LSB 8
`define MCE_SIZE_EXPBITS_LSB 16
`define MCE_STAT_BUSY 0
`define MCE_STAT_DONE 1
`define MCE_STAT_ERROR 2
`define MCE_STAT_HOSTFIN 3

// ----------------------------------------------------------------
// Entry points and memory banks
// ----------------------------------------------------------------
`define MCE_ENTRY_ADD 12'h008
`define MCE_ENTRY_SUB 12'h009
`define MCE_ENTRY_MUL 12'h00a
`define MCE_ENTRY_MUL2 12'h00b
`define MCE_ENTRY_CONST 12'h00c
`define MCE_BANK_A 2'h0
`define MCE_BANK_B 2'h1
`define MCE_BANK_N 2'h2

// ----------------------------------------------------------------
// Reset values, digit sizes and timing terms (clock periods)
// ----------------------------------------------------------------
`define MCE_CTRL_RESET 12'h000
`define MCE_DIGIT_BITS 16
`define MCE_MIN_DIGITS 9'd4
`define MCE_MUL_WCS_K1 32'd10
`define MCE_MUL_WCS_K0 32'd27
`define MCE_MUL_BCS_K1 32'd9
`define MCE_MUL_BCS_K0 32'd22
`define MCE_ADD_WCS_K1 32'd4
`define MCE_ADD_WCS_K0 32'd11
`define MCE_ADD_BCS_K1 32'd3
`define MCE_ADD_BCS_K0 32'd6
`define MCE_SUB_WCS_K1 32'd3
`define MCE_SUB_WCS_K0 32'd11
`define MCE_SUB_BCS_K1 32'd2
`define MCE_SUB_BCS_K0 32'd6
`define MCE_PADD_MULS 32'd20
`define MCE_PADD_ADDS 32'd7
`define MCE_PADD_MOVES 32'd15

`endif

// >>> rtl/mce_engine.sv
// Purpose: Montgomery constant engine with timed arithmetic routines, APB slave
// Assumes: Host loads operands through the memory window and keeps preconditions
// Notes: Only the constant routine computes data; other routines only occupy their run time
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "mce_defs.svh"

module mce_engine #(
  parameter int SEG_DIGITS = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Engine state
  output logic busy
);
  localparam int IW = $clog2(4 * SEG_DIGITS);
  localparam int AW = IW + 2;
  localparam int NW = `MCE_DIGIT_BITS * 4 * SEG_DIGITS;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  mce_pkg::mce_state_e state_ff;
  logic [11:0] entry_ff;
  logic binField_ff, projSel_ff, crtSel_ff, crtRun_ff, done_ff, error_ff, rdWait_ff;
  logic [7:0] modDigits_ff, expDigits_ff;
  logic [15:0] expBits_ff, dblCnt_ff;
  logic [AW-1:0] memAddr_ff;
  logic [3:0] estSel_ff;
  logic [31:0] estimate_ff, lastRun_ff, runCnt_ff, timer_ff;
  logic [1:0] cadence_ff;
  logic [NW-1:0] modulus_ff, accum_ff;

  logic apbAcc, apbDone, wrStrobe, mapped, isMemData, memWe;
  logic startReq, startCrt, startBad, worstNow;
  logic [AW-1:0] memAddr;
  logic [15:0] memWdata, memRdata;
  logic [11:0] startEntry;
  logic [8:0] idx_ff, dCnt, eCnt, storeBase;
  logic [31:0] ms, mulW, mulB, mulAvg, addW, addB, subW, subB, timedCycles;
  logic [NW:0] dbl, modExt;
  logic [NW-1:0] dblRed;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apbAcc = psel && penable;
  assign isMemData = (paddr == `MCE_OFF_MEMDATA);
  assign mapped = (paddr == `MCE_OFF_CTRL) || (paddr == `MCE_OFF_SIZE) ||
                  (paddr == `MCE_OFF_STATUS) || (paddr == `MCE_OFF_MEMADDR) ||
                  isMemData || (paddr == `MCE_OFF_ESTSEL) ||
                  (paddr == `MCE_OFF_ESTIMATE) || (paddr == `MCE_OFF_LASTRUN);
  // A memory read waits one cycle for the registered read data
  assign pready = !(apbAcc && !pwrite && isMemData && !busy && !rdWait_ff);
  assign apbDone = apbAcc && pready;
  assign wrStrobe = apbDone && pwrite;
  // Memory window is refused while the engine owns the memory
  assign pslverr = apbDone && (!mapped || (isMemData && busy));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdWait_ff <= 1'b0;
    end else begin
      rdWait_ff <= apbAcc && !pwrite && isMemData && !busy && !rdWait_ff;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `MCE_OFF_CTRL: begin
        prdata[11:0] = entry_ff;
        prdata[`MCE_CTRL_BINFIELD] = binField_ff;
        prdata[`MCE_CTRL_PROJ] = projSel_ff;
        prdata[`MCE_CTRL_CRT] = crtSel_ff;
      end
      `MCE_OFF_SIZE: begin
        prdata = {expBits_ff, expDigits_ff, modDigits_ff};
      end
      `MCE_OFF_STATUS: begin
        prdata[`MCE_STAT_BUSY] = busy;
        prdata[`MCE_STAT_DONE] = done_ff;
        prdata[`MCE_STAT_ERROR] = error_ff;
        prdata[`MCE_STAT_HOSTFIN] = !projSel_ff;
      end
      `MCE_OFF_MEMADDR: prdata[AW-1:0] = memAddr_ff;
      `MCE_OFF_MEMDATA: prdata[15:0] = busy ? 16'h0000 : memRdata;
      `MCE_OFF_ESTSEL: prdata[3:0] = estSel_ff;
      `MCE_OFF_ESTIMATE: prdata = estimate_ff;
      `MCE_OFF_LASTRUN: prdata = lastRun_ff;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Size and mode stay frozen during a run so the sequencer sees stable values
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      entry_ff <= `MCE_CTRL_RESET;
      binField_ff <= 1'b0;
      projSel_ff <= 1'b0;
      crtSel_ff <= 1'b0;
      modDigits_ff <= 8'h00;
      expDigits_ff <= 8'h00;
      expBits_ff <= 16'h0000;
      estSel_ff <= 4'h0;
    end else if (wrStrobe && !busy) begin
      case (paddr)
        `MCE_OFF_CTRL: begin
          entry_ff <= pwdata[11:0];
          binField_ff <= pwdata[`MCE_CTRL_BINFIELD];
          projSel_ff <= pwdata[`MCE_CTRL_PROJ];
          crtSel_ff <= pwdata[`MCE_CTRL_CRT];
        end
        `MCE_OFF_SIZE: begin
          modDigits_ff <= pwdata[7:0];
          expDigits_ff <= pwdata[`MCE_SIZE_EXPDIG_LSB +: 8];
          expBits_ff <= pwdata[`MCE_SIZE_EXPBITS_LSB +: 16];
        end
        `MCE_OFF_ESTSEL: estSel_ff <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Window pointer steps after each completed data access
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      memAddr_ff <= '0;
    end else if (apbDone && !busy) begin
      if (pwrite && paddr == `MCE_OFF_MEMADDR) begin
        memAddr_ff <= pwdata[AW-1:0];
      end else if (isMemData) begin
        memAddr_ff <= memAddr_ff + AW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Run-time terms
  // ----------------------------------------------------------------
  assign dCnt = {1'b0, modDigits_ff} + 9'd1;
  assign ms = {23'd0, dCnt};
  assign mulW = ms * ms + `MCE_MUL_WCS_K1 * ms + `MCE_MUL_WCS_K0;
  assign mulB = ms * ms + `MCE_MUL_BCS_K1 * ms + `MCE_MUL_BCS_K0;
  assign mulAvg = (32'd3 * mulB + mulW) >> 2;
  assign addW = `MCE_ADD_WCS_K1 * ms + `MCE_ADD_WCS_K0;
  assign addB = `MCE_ADD_BCS_K1 * ms + `MCE_ADD_BCS_K0;
  assign subW = `MCE_SUB_WCS_K1 * ms + `MCE_SUB_WCS_K0;
  assign subB = `MCE_SUB_BCS_K1 * ms + `MCE_SUB_BCS_K0;

  // Software picks a figure; registered so the read path stays short
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      estimate_ff <= 32'h0000_0000;
    end else begin
      case (estSel_ff)
        4'h0: estimate_ff <= mulW;
        4'h1: estimate_ff <= mulB;
        4'h2: estimate_ff <= {mulW[30:0], 1'b0};
        4'h3: estimate_ff <= {mulB[30:0], 1'b0};
        4'h4: estimate_ff <= addW;
        4'h5: estimate_ff <= addB;
        4'h6: estimate_ff <= subW;
        4'h7: estimate_ff <= subB;
        4'h8: estimate_ff <= mulAvg;
        4'h9: estimate_ff <= ((32'd3 * {16'd0, expBits_ff} * mulAvg) >> 1) + mulW;
        4'ha: estimate_ff <= `MCE_PADD_MULS * mulAvg + `MCE_PADD_ADDS * addW +
                             `MCE_PADD_MOVES * ms;
        default: estimate_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Start checks
  // ----------------------------------------------------------------
  assign startReq = wrStrobe && paddr == `MCE_OFF_CTRL && pwdata[`MCE_CTRL_START] && !busy;
  assign startEntry = pwdata[11:0];
  assign startCrt = pwdata[`MCE_CTRL_CRT];
  assign eCnt = startCrt ? ({1'b0, expDigits_ff} + 9'd1) : dCnt;
  // Plain R squared has E equal to D; the result must fit one segment
  assign storeBase = crtRun_ff ? 9'd0 : 9'(SEG_DIGITS);
  // Every fourth timed run takes the worst-case figure
  assign worstNow = (cadence_ff == 2'd3);

  always_comb begin
    startBad = 1'b0;
    timedCycles = 32'd1;
    case (startEntry)
      `MCE_ENTRY_CONST: begin
        // The shift-subtract loop needs an integer modulus with a real top digit
        startBad = pwdata[`MCE_CTRL_BINFIELD] || dCnt < `MCE_MIN_DIGITS ||
                   dCnt > (startCrt ? 9'(4 * SEG_DIGITS) : 9'(SEG_DIGITS));
      end
      `MCE_ENTRY_ADD: begin
        startBad = dCnt < `MCE_MIN_DIGITS;
        timedCycles = worstNow ? addW : addB;
      end
      `MCE_ENTRY_SUB: begin
        startBad = dCnt < `MCE_MIN_DIGITS;
        timedCycles = worstNow ? subW : subB;
      end
      `MCE_ENTRY_MUL: timedCycles = worstNow ? mulW : mulB;
      `MCE_ENTRY_MUL2: timedCycles = worstNow ? {mulW[30:0], 1'b0} : {mulB[30:0], 1'b0};
      default: startBad = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Modular doubling datapath
  // ----------------------------------------------------------------
  // Accumulator stays below the modulus, so one subtract per doubling suffices
  assign dbl = {accum_ff, 1'b0};
  assign modExt = {1'b0, modulus_ff};
  assign dblRed = (dbl >= modExt) ? NW'(dbl - modExt) : dbl[NW-1:0];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign busy = (state_ff != mce_pkg::ST_IDLE);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= mce_pkg::ST_IDLE;
      idx_ff <= 9'd0;
      dblCnt_ff <= 16'h0000;
      timer_ff <= 32'h0000_0000;
      runCnt_ff <= 32'h0000_0000;
      lastRun_ff <= 32'h0000_0000;
      cadence_ff <= 2'd0;
      crtRun_ff <= 1'b0;
      done_ff <= 1'b0;
      error_ff <= 1'b0;
      modulus_ff <= '0;
      accum_ff <= '0;
    end else begin
      if (busy) begin
        runCnt_ff <= runCnt_ff + 32'd1;
      end
      case (state_ff)
        mce_pkg::ST_IDLE: begin
          if (startReq) begin
            done_ff <= 1'b0;
            error_ff <= 1'b0;
            runCnt_ff <= 32'h0000_0000;
            idx_ff <= 9'd0;
            crtRun_ff <= startCrt;
            modulus_ff <= '0;
            if (startBad) begin
              error_ff <= 1'b1;
              done_ff <= 1'b1;
            end else if (startEntry == `MCE_ENTRY_CONST) begin
              state_ff <= mce_pkg::ST_LOAD;
              dblCnt_ff <= 16'({dCnt, 4'h0} + {eCnt, 4'h0});
            end else begin
              state_ff <= mce_pkg::ST_TIMED;
              timer_ff <= timedCycles;
              cadence_ff <= cadence_ff + 2'd1;
            end
          end
        end
        mce_pkg::ST_LOAD: begin
          if (idx_ff != 9'd0) begin
            modulus_ff[`MCE_DIGIT_BITS * (int'(idx_ff) - 1) +: `MCE_DIGIT_BITS] <= memRdata;
          end
          idx_ff <= idx_ff + 9'd1;
          if (idx_ff == dCnt) begin
            if (memRdata == 16'h0000) begin
              state_ff <= mce_pkg::ST_IDLE;
              error_ff <= 1'b1;
              done_ff <= 1'b1;
              lastRun_ff <= runCnt_ff + 32'd1;
            end else begin
              state_ff <= mce_pkg::ST_CALC;
              accum_ff <= NW'(1);
            end
          end
        end
        mce_pkg::ST_CALC: begin
          accum_ff <= dblRed;
          dblCnt_ff <= dblCnt_ff - 16'd1;
          if (dblCnt_ff == 16'd1) begin
            state_ff <= mce_pkg::ST_STORE;
            idx_ff <= 9'd0;
          end
        end
        mce_pkg::ST_STORE: begin
          idx_ff <= idx_ff + 9'd1;
          if (idx_ff == dCnt - 9'd1) begin
            state_ff <= mce_pkg::ST_IDLE;
            done_ff <= 1'b1;
            lastRun_ff <= runCnt_ff + 32'd1;
          end
        end
        mce_pkg::ST_TIMED: begin
          timer_ff <= timer_ff - 32'd1;
          if (timer_ff == 32'd1) begin
            state_ff <= mce_pkg::ST_IDLE;
            done_ff <= 1'b1;
            lastRun_ff <= runCnt_ff + 32'd1;
          end
        end
        default: state_ff <= mce_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  // The engine never writes bank N, so the modulus survives every run
  always_comb begin
    memWe = 1'b0;
    memAddr = memAddr_ff;
    memWdata = pwdata[15:0];
    case (state_ff)
      mce_pkg::ST_IDLE: memWe = wrStrobe && isMemData;
      mce_pkg::ST_LOAD: memAddr = {`MCE_BANK_N, idx_ff[IW-1:0]};
      mce_pkg::ST_STORE: begin
        memWe = 1'b1;
        memAddr = {`MCE_BANK_B, IW'(storeBase + idx_ff)};
        memWdata = accum_ff[`MCE_DIGIT_BITS * int'(idx_ff) +: `MCE_DIGIT_BITS];
      end
      default: memWe = 1'b0;
    endcase
  end

  mce_mem #(
    .WIDTH(`MCE_DIGIT_BITS),
    .DEPTH(1 << AW)
  ) u_mem (
    .clock(clock),
    .we(memWe),
    .addr(memAddr),
    .wdata(memWdata),
    .rdata(memRdata)
  );
endmodule

// >>> rtl/mce_mem.sv
// Purpose: Operand memory for the A, B and N banks
// Assumes: One port, synchronous write
// Notes: Read data come from a register, one cycle after the address
`timescale 1ns/1ps
module mce_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 128
) (
  // Clock
  input wire logic clock,
  // Port
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] store [DEPTH];

  // No reset on the array; contents are software's business
  always_ff @(posedge clock) begin
    if (we) begin
      store[addr] <= wdata;
    end
    rdata <= store[addr];
  end
endmodule

// >>> rtl/mce_pkg.sv
// Purpose: Types shared by the constant engine files
// Assumes: Nothing beyond the defs header
// Notes: Gray codes along idle, load, calc, store
package mce_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_CALC  = 3'b011,
    ST_STORE = 3'b010,
    ST_TIMED = 3'b110
  } mce_state_e;
endpackage

// >>> verification/mce_engine_assertions.sv
// Purpose: Port-level checks of the constant engine's bus and run behaviour
// Assumes: Register map and wait states as handed over with the design
// Notes: Bound to every mce_engine instance
`timescale 1ns/1ps
module mce_engine_checker #(
  parameter int SEG_DIGITS = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Engine
  input wire logic busy
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic mapped;
  logic startReq;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= 12'h01c);
  assign startReq = psel && penable && pready && pwrite && (paddr == 12'h000) && pwdata[31];
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_busy_cause: assert property ($rose(busy) |-> $past(startReq)) else $error("busy rose without start");
  a_refuse_mem: assert property (psel && penable && busy && paddr == 12'h010 |->
    pready && pslverr && prdata == 32'h0) else $error("memory window open while busy");
  a_unmap_err: assert property (psel && penable && !mapped |-> pready && pslverr) else $error("unmapped not refused");
  a_map_clean: assert property (psel && penable && mapped && !(busy && paddr == 12'h010) |-> !pslverr)
    else $error("error on legal access");
  a_read_wait: assert property ($rose(penable) && psel && !pwrite && paddr == 12'h010 && !busy |->
    !pready ##1 pready) else $error("memory read wait wrong");
  a_ready_now: assert property (psel && penable && !(paddr == 12'h010 && !pwrite && !busy) |-> pready)
    else $error("unexpected wait state");
  a_busy_min: assert property ($rose(busy) |-> busy [*8]) else $error("run shorter than any routine");
  a_start_rd0: assert property (psel && penable && !pwrite && paddr == 12'h000 |-> !prdata[31])
    else $error("start bit reads back");
  a_status_busy: assert property (psel && penable && !pwrite && paddr == 12'h008 |-> prdata[0] == busy)
    else $error("status busy differs");
endmodule
bind mce_engine mce_engine_checker #(.SEG_DIGITS(SEG_DIGITS)) chk (.clock(clock), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .busy(busy));

// >>> verification/mce_host_model.sv
// Purpose: APB master standing in for the host processor
// Assumes: Called from a process that runs in step with clock
// Notes: Waits for pready without assuming a latency
`timescale 1ns/1ps
module mce_host_model (
  // Clock
  input wire logic clock,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // No latency is assumed: only the bench watchdog ends a wait for pready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

// >>> verification/test_montgomery_constant_engine.sv
// Purpose: Self-checking bench for the constant engine
// Assumes: SEG_DIGITS of 8, operand pointer {bank, digit}
// Notes: Expected constants are worked out here by shift and subtract
`timescale 1ns/1ps
module test_montgomery_constant_engine;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int miscompares = 0;
  int n_tests = 0;
  localparam logic [79:0] MODN = 80'hd2b7_c3a5_1f27_8e4d_b619;
  always #20 clock = ~clock;
  mce_engine #(.SEG_DIGITS(8)) dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
  mce_host_model host (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    host.xfer(1'b1, a, d, q, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask
  task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, a, 32'h0, q, e);
    chk(nm, exp, q);
  endtask
  function automatic logic [79:0] powMod(input int k);
    logic [80:0] r;
    r = 81'h1;
    repeat (k) begin
      r = r << 1;
      if (r >= {1'b0, MODN}) r = r - {1'b0, MODN};
    end
    return r[79:0];
  endfunction
  task automatic digits(input string nm, input logic [11:0] base, input logic [79:0] v);
    wr(12'h00c, {20'h0, base});
    for (int i = 0; i < 5; i++) rdChk(nm, 12'h010, {16'h0, v[16*i +: 16]});
  endtask
  task automatic loadN();
    wr(12'h00c, 32'h40);
    for (int i = 0; i < 5; i++) wr(12'h010, {16'h0, MODN[16*i +: 16]});
  endtask
  // Polls status so the run length is never assumed
  task automatic runCase(input logic [31:0] ctl, input logic [31:0] stExp);
    logic [31:0] st;
    logic e;
    int n;
    wr(12'h000, ctl | 32'h8000_0000);
    n = 0;
    do begin
      host.xfer(1'b0, 12'h008, 32'h0, st, e);
      n++;
    end while (st[0] !== 1'b0 && n < 300);
    chk("status", stExp, st);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    rdChk("ctrl", 12'h000, 32'h0);
    rdChk("size", 12'h004, 32'h0);
    rdChk("status", 12'h008, 32'h8);
    chk("busy", 32'h0, {31'h0, busy});
  endtask
  task automatic testUnmapped();
    logic [31:0] q;
    logic e;
    host.xfer(1'b0, 12'h020, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask
  task automatic testTimed();
    logic [11:0] ent [8] = '{12'h00a, 12'h00a, 12'h00a, 12'h00a, 12'h008, 12'h009, 12'h00b, 12'h009};
    int cyc [8] = '{74, 74, 74, 83, 18, 14, 148, 23};
    wr(12'h004, 32'h3);
    for (int i = 0; i < 8; i++) begin
      runCase({20'h0, ent[i]}, 32'ha);
      rdChk("run cycles", 12'h01c, cyc[i]);
    end
  endtask
  task automatic testR2();
    logic [31:0] q;
    logic e;
    wr(12'h004, 32'h4);
    loadN();
    wr(12'h000, 32'h8000_200c);
    host.xfer(1'b0, 12'h010, 32'h0, q, e);
    chk("busy memory error", 32'h1, {31'h0, e});
    wr(12'h004, 32'h0);
    runCase(32'h0, 32'h2);
    rdChk("run cycles", 12'h01c, 32'd171);
    rdChk("size kept", 12'h004, 32'h4);
    digits("square", 12'h028, powMod(160));
    digits("modulus", 12'h040, MODN);
  endtask
  task automatic testCrt();
    wr(12'h004, 32'h0904);
    loadN();
    runCase(32'h0000_400c, 32'ha);
    rdChk("run cycles", 12'h01c, 32'd251);
    digits("crt const", 12'h020, powMod(240));
    digits("modulus", 12'h040, MODN);
  endtask
  task automatic testErrors();
    logic [31:0] sz [5] = '{32'h3, 32'h2, 32'h3, 32'h2, 32'h8};
    logic [31:0] ct [5] = '{32'h100c, 32'h000c, 32'h0005, 32'h0008, 32'h000c};
    for (int i = 0; i < 5; i++) begin
      wr(12'h004, sz[i]);
      runCase(ct[i], 32'he);
    end
  endtask
  task automatic testEstimate();
    int est [12] = '{83, 74, 166, 148, 27, 18, 23, 14, 76, 995, 1769, 0};
    wr(12'h004, 32'h0008_0003);
    for (int i = 0; i < 12; i++) begin
      wr(12'h014, 32'(i));
      rdChk("estimate", 12'h018, est[i]);
    end
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    testReset();
    testUnmapped();
    testTimed();
    testR2();
    testCrt();
    testErrors();
    testEstimate();
    conclude();
  end
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    conclude();
  end
endmodule
